// ---- logic/rsq_pkg.sv ----
package rsq_pkg;

   // Clock and stage timing, figures in ns and derived cycle counts.
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned POR_DELAY_NS   = 10000;
   localparam int unsigned BOR_DELAY_NS   = 10000;
   localparam int unsigned POWER_UP_TIMER_UNIT_NS   = 1000000;
   localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_DELAY_NS  = 100000;
   localparam int unsigned POR_DELAY_CYC  = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BOR_DELAY_CYC  = (BOR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned POWER_UP_TIMER_UNIT_CYC  = (POWER_UP_TIMER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_DELAY_CYC = (FAIL_SAFE_CLOCK_MONITOR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W        = 32;

   localparam logic [23:0] RESET_VECTOR = 24'h000000;

   // Register map, byte addresses.
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFS_TRAP     = 8'h00;
   localparam logic [7:0]  OFS_CTRL     = 8'h04;
   localparam logic [7:0]  OFS_STATE    = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STAT = 8'h0c;
   localparam logic [7:0]  OFS_IRQ_CLR  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_EN   = 8'h14;

   localparam int unsigned TRAP_OSCILLATOR_FAILURE_FLAG_BIT = 1;
   localparam int unsigned CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT    = 0;
   localparam int unsigned CTRL_POWER_UP_TIMER_LSB    = 1;
   localparam int unsigned POWER_UP_TIMER_SEL_W       = 3;
   localparam int unsigned STATE_W          = 5;
   localparam int unsigned STATE_MON_BIT    = 8;
   localparam int unsigned IRQ_W            = 3;
   localparam int unsigned IRQ_RUN_BIT      = 0;
   localparam int unsigned IRQ_FAIL_BIT     = 1;
   localparam int unsigned IRQ_BOR_BIT      = 2;
   localparam int unsigned HTRANS_ACT_BIT   = 1;
   localparam logic        HRESP_OKAY       = 1'b0;

   typedef enum logic [4:0] {
      ST_POR  = 5'h01,
      ST_BOR  = 5'h02,
      ST_POWER_UP_TIMER = 5'h04,
      ST_OSC  = 5'h08,
      ST_RUN  = 5'h10
   } rsq_state_e;

   typedef struct packed {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
   } rsq_aphase_s;

   typedef struct packed {
      logic                  fail_safe_clock_monitor_en;
      logic [POWER_UP_TIMER_SEL_W-1:0] power_up_timer_sel;
   } rsq_ctrl_s;

   localparam rsq_ctrl_s CTRL_RESET = '{fail_safe_clock_monitor_en: 1'b0, power_up_timer_sel: 3'h0};

   typedef struct packed {
      logic clk_fail;
      logic osc_ready;
      logic bor_ok;
      logic por_ok;
   } rsq_pins_s;

endpackage : rsq_pkg

// ---- logic/rsq_sync3.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; the output moves only once stages two and three agree.
module rsq_sync3 #(
   parameter int unsigned W = 1
) (
   input  wire logic         mclk_in,
   input  wire logic         rst_b_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end else begin
         s1_ff <= d_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
      end
   end

   assign q_out = q_ff;

endmodule : rsq_sync3

// ---- logic/rsq_sequencer.sv ----
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module rsq_sequencer #(
   parameter int unsigned POWER_UP_TIMER_UNIT_CYC  = rsq_pkg::POWER_UP_TIMER_UNIT_CYC,
   parameter int unsigned FAIL_SAFE_CLOCK_MONITOR_DELAY_CYC = rsq_pkg::FAIL_SAFE_CLOCK_MONITOR_DELAY_CYC
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        por_cmp_in,
   input  wire logic        bor_cmp_in,
   input  wire logic        osc_ready_in,
   input  wire logic        clk_fail_in,
   output logic             system_reset_line_out,
   output logic             osc_enable_out,
   output logic             cpu_reset_out,
   output logic      [23:0] reset_vector_out,
   output logic             monitor_active_out,
   output logic             irq_out
);

   localparam int unsigned TW = rsq_pkg::TIMER_W;

   rsq_pkg::rsq_pins_s       pins;
   rsq_pkg::rsq_state_e      state_ff;
   rsq_pkg::rsq_state_e      nxt_state;
   logic [TW-1:0]            timer_ff;
   logic [TW-1:0]            nxt_timer;
   logic [TW-1:0]            fail_safe_clock_monitor_cnt_ff;
   logic [TW-1:0]            power_up_timer_len;
   logic                     system_reset_line_ff;
   logic                     cpu_reset_ff;
   logic                     monitor_ff;
   logic                     oscillator_failure_flag_ff;
   logic [23:0]              vector_ff;
   rsq_pkg::rsq_ctrl_s       ctrl_ff;
   logic [rsq_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [rsq_pkg::IRQ_W-1:0] irq_en_ff;
   logic [rsq_pkg::IRQ_W-1:0] irq_evt;
   rsq_pkg::rsq_aphase_s     ap_ff;
   logic                     rd_wait_ff;
   logic [31:0]              hrdata_ff;
   logic [31:0]              rd_val;
   logic                     ap_take;
   logic                     wr_stb;
   logic                     fail_evt;
   logic                     bor_evt;
   logic                     run_evt;

   // Supply comparators, oscillator ready and clock failure all arrive asynchronously.
   rsq_sync3 #(
      .W ($bits(rsq_pkg::rsq_pins_s))
   ) u_sync (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .d_in     ({clk_fail_in, osc_ready_in, bor_cmp_in, por_cmp_in}),
      .q_out    (pins)
   );

   always_comb begin
      if (ctrl_ff.power_up_timer_sel == '0) begin
         power_up_timer_len = TW'(1);
      end else begin
         power_up_timer_len = TW'(POWER_UP_TIMER_UNIT_CYC) << (ctrl_ff.power_up_timer_sel - 3'h1);
      end
   end

   // A power-on drop always wins over the sequence and a brown-out wins outside ST_POR, so a brown-out mid-boot restarts cleanly.
   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_ff;
      if (!pins.por_ok) begin
         nxt_state = rsq_pkg::ST_POR;
         nxt_timer = TW'(rsq_pkg::POR_DELAY_CYC);
      end else if (!pins.bor_ok && state_ff != rsq_pkg::ST_POR) begin
         nxt_state = rsq_pkg::ST_BOR;
         nxt_timer = TW'(rsq_pkg::BOR_DELAY_CYC);
      end else begin
         case (state_ff)
            rsq_pkg::ST_POR: begin
               if (timer_ff == '0) begin
                  nxt_state = rsq_pkg::ST_BOR;
                  nxt_timer = TW'(rsq_pkg::BOR_DELAY_CYC);
               end else begin
                  nxt_timer = timer_ff - TW'(1);
               end
            end
            rsq_pkg::ST_BOR: begin
               if (timer_ff == '0) begin
                  nxt_state = rsq_pkg::ST_POWER_UP_TIMER;
                  nxt_timer = power_up_timer_len;
               end else begin
                  nxt_timer = timer_ff - TW'(1);
               end
            end
            rsq_pkg::ST_POWER_UP_TIMER: begin
               if (timer_ff == '0) begin
                  nxt_state = rsq_pkg::ST_OSC;
               end else begin
                  nxt_timer = timer_ff - TW'(1);
               end
            end
            rsq_pkg::ST_OSC: begin
               if (pins.osc_ready) begin
                  nxt_state = rsq_pkg::ST_RUN;
               end
            end
            rsq_pkg::ST_RUN: begin
               nxt_state = rsq_pkg::ST_RUN;
            end
            default: begin
               nxt_state = rsq_pkg::ST_POR;
               nxt_timer = TW'(rsq_pkg::POR_DELAY_CYC);
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_ff <= rsq_pkg::ST_POR;
         timer_ff <= TW'(rsq_pkg::POR_DELAY_CYC);
      end else begin
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         system_reset_line_ff    <= 1'b1;
         cpu_reset_ff <= 1'b1;
         vector_ff    <= rsq_pkg::RESET_VECTOR;
      end else begin
         // system reset drops after the timer
         system_reset_line_ff    <= (nxt_state == rsq_pkg::ST_POR) || (nxt_state == rsq_pkg::ST_BOR) ||
                         (nxt_state == rsq_pkg::ST_POWER_UP_TIMER);
         cpu_reset_ff <= (nxt_state != rsq_pkg::ST_RUN);
         vector_ff    <= rsq_pkg::RESET_VECTOR;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         fail_safe_clock_monitor_cnt_ff <= TW'(FAIL_SAFE_CLOCK_MONITOR_DELAY_CYC);
         monitor_ff  <= 1'b0;
      end else if (state_ff != rsq_pkg::ST_RUN || !ctrl_ff.fail_safe_clock_monitor_en) begin
         fail_safe_clock_monitor_cnt_ff <= TW'(FAIL_SAFE_CLOCK_MONITOR_DELAY_CYC);
         monitor_ff  <= 1'b0;
      end else if (fail_safe_clock_monitor_cnt_ff != '0) begin
         fail_safe_clock_monitor_cnt_ff <= fail_safe_clock_monitor_cnt_ff - TW'(1);
      end else begin
         monitor_ff  <= 1'b1;
      end
   end

   assign fail_evt = monitor_ff & pins.clk_fail;
   assign bor_evt  = pins.por_ok & ~pins.bor_ok & (state_ff != rsq_pkg::ST_POR) &
                     (state_ff != rsq_pkg::ST_BOR);
   assign run_evt  = (state_ff == rsq_pkg::ST_OSC) && (nxt_state == rsq_pkg::ST_RUN);

   // Bus slave: reads take one wait state so the data comes from a flop and sees prior writes.
   assign ap_take = hsel_in & htrans_in[rsq_pkg::HTRANS_ACT_BIT] & hready_in;
   assign wr_stb  = ap_ff.valid & ap_ff.write & hready_in;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ap_ff      <= '0;
         rd_wait_ff <= 1'b0;
      end else begin
         if (hready_in) begin
            ap_ff <= '{valid: ap_take, write: hwrite_in, addr: haddr_in[rsq_pkg::ADDR_W-1:0]};
         end
         rd_wait_ff <= ap_take & ~hwrite_in;
      end
   end

   always_comb begin
      rd_val = '0;
      case (ap_ff.addr)
         rsq_pkg::OFS_TRAP: begin
            rd_val[rsq_pkg::TRAP_OSCILLATOR_FAILURE_FLAG_BIT] = oscillator_failure_flag_ff;
         end
         rsq_pkg::OFS_CTRL: begin
            rd_val[rsq_pkg::CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT] = ctrl_ff.fail_safe_clock_monitor_en;
            rd_val[rsq_pkg::CTRL_POWER_UP_TIMER_LSB +: rsq_pkg::POWER_UP_TIMER_SEL_W] = ctrl_ff.power_up_timer_sel;
         end
         rsq_pkg::OFS_STATE: begin
            rd_val[rsq_pkg::STATE_W-1:0]   = state_ff;
            rd_val[rsq_pkg::STATE_MON_BIT] = monitor_ff;
         end
         rsq_pkg::OFS_IRQ_STAT: begin
            rd_val[rsq_pkg::IRQ_W-1:0] = irq_stat_ff;
         end
         rsq_pkg::OFS_IRQ_EN: begin
            rd_val[rsq_pkg::IRQ_W-1:0] = irq_en_ff;
         end
         default: begin
            rd_val = '0;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hrdata_ff <= '0;
      end else if (rd_wait_ff) begin
         hrdata_ff <= rd_val;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_ff   <= rsq_pkg::CTRL_RESET;
         irq_en_ff <= '0;
      end else if (wr_stb) begin
         if (ap_ff.addr == rsq_pkg::OFS_CTRL) begin
            ctrl_ff <= '{fail_safe_clock_monitor_en:  hwdata_in[rsq_pkg::CTRL_FAIL_SAFE_CLOCK_MONITOR_BIT],
                         power_up_timer_sel: hwdata_in[rsq_pkg::CTRL_POWER_UP_TIMER_LSB +: rsq_pkg::POWER_UP_TIMER_SEL_W]};
         end
         if (ap_ff.addr == rsq_pkg::OFS_IRQ_EN) begin
            irq_en_ff <= hwdata_in[rsq_pkg::IRQ_W-1:0];
         end
      end
   end

   // failure trap flag, set wins over a clearing write of 0
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         oscillator_failure_flag_ff <= 1'b0;
      end else if (fail_evt) begin
         oscillator_failure_flag_ff <= 1'b1;
      end else if (wr_stb && ap_ff.addr == rsq_pkg::OFS_TRAP &&
                   !hwdata_in[rsq_pkg::TRAP_OSCILLATOR_FAILURE_FLAG_BIT]) begin
         oscillator_failure_flag_ff <= 1'b0;
      end
   end

   always_comb begin
      irq_evt = '0;
      irq_evt[rsq_pkg::IRQ_RUN_BIT]  = run_evt;
      irq_evt[rsq_pkg::IRQ_FAIL_BIT] = fail_evt;
      irq_evt[rsq_pkg::IRQ_BOR_BIT]  = bor_evt;
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_stat_ff <= '0;
      end else if (wr_stb && ap_ff.addr == rsq_pkg::OFS_IRQ_CLR) begin
         irq_stat_ff <= (irq_stat_ff & ~hwdata_in[rsq_pkg::IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_evt;
      end
   end

   assign hrdata_out            = hrdata_ff;
   assign hreadyout_out         = ~rd_wait_ff;
   assign hresp_out             = rsq_pkg::HRESP_OKAY;
   assign system_reset_line_out = system_reset_line_ff;
   assign osc_enable_out        = ~system_reset_line_ff;
   assign cpu_reset_out         = cpu_reset_ff;
   assign reset_vector_out      = vector_ff;
   assign monitor_active_out    = monitor_ff;
   assign irq_out               = |(irq_stat_ff & irq_en_ff);

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_bor_release;
      (state_ff == rsq_pkg::ST_BOR) ##1 (state_ff == rsq_pkg::ST_POWER_UP_TIMER);
   endsequence

   sequence s_system_reset_line_drop;
      (state_ff == rsq_pkg::ST_POWER_UP_TIMER) ##1 $fell(system_reset_line_out);
   endsequence

   a_por_hold:
   assert property (!pins.por_ok |=> system_reset_line_out && state_ff == rsq_pkg::ST_POR)
      else $error("power-on stage released while supply low");

   a_por_delay:
   assert property ((state_ff == rsq_pkg::ST_POR) ##1 (state_ff == rsq_pkg::ST_BOR)
                    |-> $past(timer_ff) == '0)
      else $error("power-on stage left before its delay");

   a_bor_hold:
   assert property (pins.por_ok && !pins.bor_ok |=> cpu_reset_out &&
                    (state_ff == rsq_pkg::ST_POR || state_ff == rsq_pkg::ST_BOR))
      else $error("brown-out stage released while supply low");

   a_bor_delay:
   assert property (s_bor_release |-> $past(timer_ff) == '0 && timer_ff == power_up_timer_len)
      else $error("brown-out delay cut short");

   a_power_up_timer_stay:
   assert property (state_ff == rsq_pkg::ST_POWER_UP_TIMER && timer_ff != '0 && pins.por_ok &&
                    pins.bor_ok |=> state_ff == rsq_pkg::ST_POWER_UP_TIMER && system_reset_line_out)
      else $error("power-up timer ended early");

   a_system_reset_line_osc:
   assert property (s_system_reset_line_drop |-> osc_enable_out && state_ff == rsq_pkg::ST_OSC)
      else $error("system reset drop did not start oscillator");

   a_run_vector:
   assert property (state_ff == rsq_pkg::ST_OSC && pins.osc_ready && pins.por_ok &&
                    pins.bor_ok |=> !cpu_reset_out && reset_vector_out == rsq_pkg::RESET_VECTOR)
      else $error("processor not started on clock ready");

   a_mon_start:
   assert property ($rose(monitor_active_out) |-> state_ff == rsq_pkg::ST_RUN &&
                    ctrl_ff.fail_safe_clock_monitor_en && $past(fail_safe_clock_monitor_cnt_ff) == '0 && $past(monitor_ff) == 1'b0)
      else $error("clock monitor started early");

   a_fail_flag:
   assert property (monitor_active_out && pins.clk_fail |=> oscillator_failure_flag_ff &&
                    irq_stat_ff[rsq_pkg::IRQ_FAIL_BIT])
      else $error("oscillator failure flag not set");

   a_cpu_combine:
   assert property (system_reset_line_out || state_ff != rsq_pkg::ST_RUN |-> cpu_reset_out)
      else $error("processor released while a stage holds");

endmodule : rsq_sequencer

// ---- sim/rsq_far_model.sv ----
`timescale 1ns/1ps
// Stand-in for the supply comparators and the oscillator beside the sequencer.
module rsq_far_model #(
   parameter int unsigned OSC_DLY = 20
) (
   input  wire logic mclk_in,
   input  wire logic supply_ok_in,
   input  wire logic bor_ok_in,
   input  wire logic fail_in,
   input  wire logic osc_enable_in,
   output logic      por_cmp_out,
   output logic      bor_cmp_out,
   output logic      osc_ready_out,
   output logic      clk_fail_out
);
   int unsigned cnt_ff;
   // The brown-out level sits above the power-on level, so a dead supply trips both.
   assign por_cmp_out = supply_ok_in;
   assign bor_cmp_out = supply_ok_in & bor_ok_in;
   always_ff @(posedge mclk_in) begin
      if (!osc_enable_in) begin
         cnt_ff <= 0;
      end else if (cnt_ff < OSC_DLY) begin
         cnt_ff <= cnt_ff + 1;
      end
   end
   assign osc_ready_out = osc_enable_in && (cnt_ff == OSC_DLY);
   // A stopped oscillator cannot fail, so failures are only reported once it runs.
   assign clk_fail_out  = fail_in & osc_ready_out;
endmodule : rsq_far_model

// ---- sim/system_reset_sequencer_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("FAIL %s expected %h seen %h", nm, e, g); end end
`define WAITV(s, v) begin n = 0; while ((s) !== (v) && n < 5000) begin \
   @(posedge mclk_in); n++; end end
module system_reset_sequencer_bench;
   localparam int unsigned PU = 8;
   localparam int unsigned FD = 16;
   localparam int unsigned OD = 20;
   logic        mclk_in, rst_b_in, hsel, hwrite, rd_ph, supply_ok, bor_ok, fail;
   logic        hready, hresp, por_cmp, bor_cmp, osc_rdy, clk_fail;
   logic        system_reset_line, osc_en, cpu_rst, mon, irq;
   logic [1:0]  htrans;
   logic [23:0] vec;
   logic [31:0] haddr, hwdata, hrdata, rnd, r_e;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          checks = 0;
   int          n, lo;

   rsq_sequencer #(.POWER_UP_TIMER_UNIT_CYC(PU), .FAIL_SAFE_CLOCK_MONITOR_DELAY_CYC(FD)) dut (
      .mclk_in(mclk_in), .rst_b_in(rst_b_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .por_cmp_in(por_cmp), .bor_cmp_in(bor_cmp),
      .osc_ready_in(osc_rdy), .clk_fail_in(clk_fail), .system_reset_line_out(system_reset_line),
      .osc_enable_out(osc_en), .cpu_reset_out(cpu_rst), .reset_vector_out(vec),
      .monitor_active_out(mon), .irq_out(irq));

   rsq_far_model #(.OSC_DLY(OD)) far (
      .mclk_in(mclk_in), .supply_ok_in(supply_ok), .bor_ok_in(bor_ok),
      .fail_in(fail), .osc_enable_in(osc_en), .por_cmp_out(por_cmp),
      .bor_cmp_out(bor_cmp), .osc_ready_out(osc_rdy), .clk_fail_out(clk_fail));

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // For a read, d carries the expected word, which the monitor takes off the queue.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      do @(posedge mclk_in); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      if (!w) begin
         exp_q.push_back(d);
         rd_ph <= 1'b1;
      end
      do @(posedge mclk_in); while (hready !== 1'b1);
      rd_ph <= 1'b0;
   endtask : bus

   task automatic pulse_fail;
      @(posedge mclk_in);
      fail <= 1'b1;
      repeat (6) @(posedge mclk_in);
      fail <= 1'b0;
      repeat (8) @(posedge mclk_in);
   endtask : pulse_fail

   always @(posedge mclk_in) begin
      if (rd_ph === 1'b1 && hready === 1'b1) begin
         r_e = exp_q.pop_front();
         `CHK("hrdata", r_e, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
   end

   task automatic finish_test;
      $display("counts: %0d comparisons, %0d mismatches", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // One power-up of about 2000 cycles, one brown-out restart of about 1000 and bus traffic fit well inside this.
   initial begin
      repeat (40000) @(posedge mclk_in);
      num_errors++;
      finish_test();
   end

   initial begin
      rst_b_in = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = '0; hwrite = 1'b0;
      hwdata = '0; rd_ph = 1'b0; supply_ok = 1'b0; bor_ok = 1'b0; fail = 1'b0;
      rnd = 32'he1393435;
      repeat (2) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      @(negedge mclk_in);
      `CHK("system_reset_line", 1'b1, system_reset_line)
      `CHK("cpu_rst", 1'b1, cpu_rst)
      `CHK("osc_en", 1'b0, osc_en)
      bus(1'b0, rsq_pkg::OFS_TRAP, 32'h0);
      bus(1'b0, rsq_pkg::OFS_CTRL, 32'h0);
      bus(1'b0, 8'h18, 32'h0);
      bus(1'b0, rsq_pkg::OFS_STATE, 32'h1);
      for (int i = 0; i < 3; i++) begin
         rnd = lfsr(rnd);
         bus(1'b1, rsq_pkg::OFS_IRQ_EN, rnd);
         bus(1'b0, rsq_pkg::OFS_IRQ_EN, rnd & 32'h7);
      end
      bus(1'b1, rsq_pkg::OFS_IRQ_EN, 32'h7);
      bus(1'b1, rsq_pkg::OFS_CTRL, 32'h5);
      bus(1'b0, rsq_pkg::OFS_CTRL, 32'h5);
      $display("test reset done");

      @(posedge mclk_in);
      supply_ok <= 1'b1;
      bor_ok    <= 1'b1;
      lo = rsq_pkg::POR_DELAY_CYC + rsq_pkg::BOR_DELAY_CYC + 2 * PU;
      `WAITV(system_reset_line, 1'b0)
      `CHK("powerup_len", 1'b1, (n >= lo && n <= lo + 16))
      @(negedge mclk_in);
      `CHK("osc_en", 1'b1, osc_en)
      `CHK("cpu_rst", 1'b1, cpu_rst)
      `WAITV(cpu_rst, 1'b0)
      `CHK("osc_wait", 1'b1, (n >= OD && n <= OD + 8))
      `CHK("vector", 24'h000000, vec)
      `CHK("mon_early", 1'b0, mon)
      `WAITV(mon, 1'b1)
      `CHK("mon_delay", 1'b1, (n >= FD - 1 && n <= FD + 3))
      bus(1'b0, rsq_pkg::OFS_STATE, 32'h110);
      bus(1'b0, rsq_pkg::OFS_IRQ_STAT, 32'h1);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, rsq_pkg::OFS_IRQ_CLR, 32'h1);
      bus(1'b0, rsq_pkg::OFS_IRQ_STAT, 32'h0);
      $display("test power-up done");

      pulse_fail();
      bus(1'b0, rsq_pkg::OFS_TRAP, 32'h2);
      bus(1'b1, rsq_pkg::OFS_TRAP, 32'h2);
      bus(1'b0, rsq_pkg::OFS_TRAP, 32'h2);
      bus(1'b1, rsq_pkg::OFS_TRAP, 32'h0);
      bus(1'b0, rsq_pkg::OFS_TRAP, 32'h0);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, rsq_pkg::OFS_IRQ_CLR, 32'h7);
      // The clear lands on the edge that ends the write, so look once it has settled.
      @(negedge mclk_in);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, rsq_pkg::OFS_IRQ_EN, 32'h0);
      pulse_fail();
      bus(1'b0, rsq_pkg::OFS_IRQ_STAT, 32'h2);
      `CHK("irq_masked", 1'b0, irq)
      bus(1'b1, rsq_pkg::OFS_IRQ_EN, 32'h7);
      @(negedge mclk_in);
      `CHK("irq", 1'b1, irq)
      bus(1'b1, rsq_pkg::OFS_IRQ_CLR, 32'h7);
      $display("test failure flag done");

      @(posedge mclk_in);
      bor_ok <= 1'b0;
      repeat (8) @(posedge mclk_in);
      @(negedge mclk_in);
      `CHK("system_reset_line", 1'b1, system_reset_line)
      `CHK("cpu_rst", 1'b1, cpu_rst)
      `CHK("osc_en", 1'b0, osc_en)
      `CHK("mon", 1'b0, mon)
      bus(1'b0, rsq_pkg::OFS_STATE, 32'h2);
      bus(1'b0, rsq_pkg::OFS_IRQ_STAT, 32'h4);
      bor_ok <= 1'b1;
      lo = rsq_pkg::BOR_DELAY_CYC + 2 * PU;
      `WAITV(system_reset_line, 1'b0)
      `CHK("bor_len", 1'b1, (n >= lo && n <= lo + 16))
      $display("test brown-out done");

      @(posedge mclk_in);
      supply_ok <= 1'b0;
      repeat (8) @(posedge mclk_in);
      @(negedge mclk_in);
      `CHK("system_reset_line", 1'b1, system_reset_line)
      `CHK("cpu_rst", 1'b1, cpu_rst)
      bus(1'b0, rsq_pkg::OFS_STATE, 32'h1);
      $display("test power-on drop done");
      finish_test();
   end
endmodule : system_reset_sequencer_bench
